// ### crf_defs.svh
/*
 Constants of the core register file and stack pointer block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_NUM_REGS 32
`define CRF_REG_LAST 8'h1F
`define CRF_PTR_X 5'h1A
`define CRF_PTR_Y 5'h1C
`define CRF_PTR_Z 5'h1E
`define CRF_IO_STACK_LOW 6'h3D
`define CRF_IO_STACK_HIGH 6'h3E
`define CRF_IO_TO_DATA 16'h0020
`define CRF_IO_DATA_LAST 16'h005F
`define CRF_DATA_STACK_LOW 16'h005D
`define CRF_DATA_STACK_HIGH 16'h005E
`define CRF_SP_WIDTH 11
`define CRF_STACK_HIGH_BITS 3
`define CRF_REG_RESET 8'h00
`define CRF_LAST_SRAM_ADDR 11'h4FF
`define CRF_SP_STEP_BYTE 11'h001
`define CRF_SP_STEP_ADDR 11'h002
`endif

// ### crf_pkg.sv
/*
 Types of the core register file and stack pointer block.
 Assumes crf_defs.svh for numeric constants.
*/
package crf_pkg;
    typedef enum logic [2:0] {
        PTR_PLAIN,
        PTR_DISP,
        PTR_POST_INC,
        PTR_PRE_DEC
    } crf_ptr_mode_t;

    typedef enum logic [2:0] {
        SP_HOLD,
        SP_PUSH_BYTE,
        SP_POP_BYTE,
        SP_PUSH_ADDR,
        SP_POP_ADDR
    } crf_sp_op_t;

    typedef enum logic [1:0] {
        PORT_R1_W8,
        PORT_R2_W8,
        PORT_R2_W16,
        PORT_R16_W16
    } crf_port_cfg_t;

    typedef struct packed {
        logic valid;
        logic [1:0] sel;
        crf_ptr_mode_t mode;
        logic [5:0] disp;
    } crf_ptr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wen;
    } crf_data_req_t;
endpackage

// ### crf_ptr_unit.sv
/*
 Pointer address arithmetic: displacement, increment and decrement.
 Assumes the selected pointer value is supplied by the register file.
*/
`timescale 1ns/100ps
`include "crf_defs.svh"
module crf_ptr_unit (
    // Request
    input wire crf_pkg::crf_ptr_req_t req,
    input wire logic [15:0] ptr_value,
    // Result
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_new,
    output logic ptr_update
);
    always_comb
    begin
        eff_addr = ptr_value;
        ptr_new = ptr_value;
        ptr_update = 1'b0;
        case (req.mode)
            crf_pkg::PTR_PLAIN:
            begin
                eff_addr = ptr_value;
            end
            crf_pkg::PTR_DISP:
            begin
                eff_addr = ptr_value + {10'h000, req.disp};
            end
            crf_pkg::PTR_POST_INC:
            begin
                ptr_new = ptr_value + 16'h0001;
                ptr_update = req.valid;
            end
            crf_pkg::PTR_PRE_DEC:
            begin
                ptr_new = ptr_value - 16'h0001;
                eff_addr = ptr_new;
                ptr_update = req.valid;
            end
            default:
            begin
                eff_addr = ptr_value;
            end
        endcase
    end
endmodule // crf_ptr_unit

// ### crf_stack_ptr.sv
/*
 Stack pointer register with push/pop arithmetic and byte access.
 Assumes one operation or one byte write per clock from the core.
*/
`timescale 1ns/100ps
`include "crf_defs.svh"
module crf_stack_ptr (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Stack operation
    input wire crf_pkg::crf_sp_op_t sp_op,
    // Byte writes
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    // State
    output logic [10:0] stack_pointer
);
    logic [10:0] sp_reg;
    logic [10:0] sp_next;

    always_comb
    begin
        sp_next = sp_reg;
        case (sp_op)
            crf_pkg::SP_PUSH_BYTE: sp_next = sp_reg - `CRF_SP_STEP_BYTE;
            crf_pkg::SP_POP_BYTE: sp_next = sp_reg + `CRF_SP_STEP_BYTE;
            crf_pkg::SP_PUSH_ADDR: sp_next = sp_reg - `CRF_SP_STEP_ADDR;
            crf_pkg::SP_POP_ADDR: sp_next = sp_reg + `CRF_SP_STEP_ADDR;
            default: sp_next = sp_reg;
        endcase
        if (wr_low)
        begin
            sp_next[7:0] = wdata;
        end
        if (wr_high)
        begin
            sp_next[10:8] = wdata[2:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sp_reg <= `CRF_LAST_SRAM_ADDR;
        end
        else
        begin
            sp_reg <= sp_next;
        end
    end

    assign stack_pointer = sp_reg;
endmodule // crf_stack_ptr

// ### crf_core_regs.sv
/*
 Working register file of the 8-bit core with pointer pairs and stack pointer.
 Assumes the decoder drives one request set per clock, all sampled at the edge.
*/
`timescale 1ns/100ps
`include "crf_defs.svh"
module crf_core_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Operand ports
    input wire crf_pkg::crf_port_cfg_t port_cfg,
    input wire logic [4:0] rd_addr_a,
    input wire logic [4:0] rd_addr_b,
    output logic [7:0] rd_data_a,
    output logic [7:0] rd_data_b,
    output logic [15:0] rd_data_wide,
    // Result write-back
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [15:0] wr_data,
    // Indirect pointer access
    input wire crf_pkg::crf_ptr_req_t ptr_req,
    output logic [15:0] ptr_eff_addr,
    // Data-space access
    input wire crf_pkg::crf_data_req_t data_req,
    output logic [7:0] data_rdata,
    output logic data_hit,
    // I/O access
    input wire logic io_en,
    input wire logic io_wen,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // Stack
    input wire crf_pkg::crf_sp_op_t sp_op,
    output logic [10:0] stack_pointer
);
    // Configuration option: drop high byte for 8-bit data spaces
    parameter bit HAS_SP_HIGH = 1'b1;

    logic [7:0] regs_reg [0:`CRF_NUM_REGS-1];
    logic [7:0] regs_next [0:`CRF_NUM_REGS-1];
    logic [15:0] ptr_value;
    logic [15:0] ptr_new;
    logic ptr_update;
    logic [4:0] ptr_base;
    logic [15:0] acc_addr;
    logic sp_wr_low;
    logic sp_wr_high;
    logic [7:0] sp_wdata;
    logic [10:0] sp_value;
    logic [7:0] rd_a_next;
    logic [7:0] rd_b_next;
    logic [15:0] rd_w_next;
    logic [7:0] data_r_next;
    logic data_hit_next;
    logic [7:0] io_r_next;
    logic io_hit_next;
    logic [7:0] rd_a_reg;
    logic [7:0] rd_b_reg;
    logic [15:0] rd_w_reg;
    logic [7:0] data_r_reg;
    logic data_hit_reg;
    logic [7:0] io_r_reg;
    logic io_hit_reg;

    // Register index is in the working register range
    function automatic logic in_reg_range(input logic [15:0] a);
        in_reg_range = (a <= {8'h00, `CRF_REG_LAST});
    endfunction

    // Byte read of the stack pointer for a given I/O address
    function automatic logic [7:0] sp_byte(input logic [5:0] a, input logic [10:0] sp);
        if (a == `CRF_IO_STACK_LOW)
        begin
            sp_byte = sp[7:0];
        end
        else if (a == `CRF_IO_STACK_HIGH && HAS_SP_HIGH)
        begin
            sp_byte = {5'h00, sp[10:8]};
        end
        else
        begin
            sp_byte = 8'h00;
        end
    endfunction

    // Is a given I/O address one of the stack pointer bytes
    function automatic logic sp_hit(input logic [5:0] a);
        sp_hit = (a == `CRF_IO_STACK_LOW) || ((a == `CRF_IO_STACK_HIGH) && HAS_SP_HIGH);
    endfunction

    // Pair member index: even register is the low byte
    function automatic logic [4:0] pair_reg(input logic [4:0] r, input logic high);
        pair_reg = {r[4:1], high};
    endfunction

    // Data-space address falls in the I/O window
    function automatic logic in_io_window(input logic [15:0] a);
        in_io_window = (a >= `CRF_IO_TO_DATA) && (a <= `CRF_IO_DATA_LAST);
    endfunction

    // I/O offset of a data-space address inside the I/O window
    function automatic logic [5:0] io_of_data(input logic [15:0] a);
        io_of_data = 6'(a - `CRF_IO_TO_DATA);
    endfunction

    // Pointer pair selection
    always_comb
    begin
        case (ptr_req.sel)
            2'h0: ptr_base = `CRF_PTR_X;
            2'h1: ptr_base = `CRF_PTR_Y;
            default: ptr_base = `CRF_PTR_Z;
        endcase
        ptr_value = {regs_reg[ptr_base + 5'h01], regs_reg[ptr_base]};
    end

    crf_ptr_unit u_ptr (
        .req(ptr_req),
        .ptr_value(ptr_value),
        .eff_addr(ptr_eff_addr),
        .ptr_new(ptr_new),
        .ptr_update(ptr_update)
    );

    // Data access address: pointer when indirect, else direct
    assign acc_addr = ptr_req.valid ? ptr_eff_addr : data_req.addr;

    // Stack pointer byte writes from I/O or data space
    always_comb
    begin
        sp_wr_low = 1'b0;
        sp_wr_high = 1'b0;
        sp_wdata = io_wdata;
        if (io_en && io_wen)
        begin
            sp_wr_low = (io_addr == `CRF_IO_STACK_LOW);
            sp_wr_high = (io_addr == `CRF_IO_STACK_HIGH) && HAS_SP_HIGH;
        end
        else if (data_req.valid && data_req.wen)
        begin
            sp_wdata = data_req.wdata;
            sp_wr_low = (acc_addr == `CRF_DATA_STACK_LOW);
            sp_wr_high = (acc_addr == `CRF_DATA_STACK_HIGH) && HAS_SP_HIGH;
        end
    end

    crf_stack_ptr u_sp (
        .clock(clock),
        .rst_n(rst_n),
        .sp_op(sp_op),
        .wr_low(sp_wr_low),
        .wr_high(sp_wr_high),
        .wdata(sp_wdata),
        .stack_pointer(sp_value)
    );

    // Register write-back; later writes take priority
    always_comb
    begin
        for (int i = 0; i < `CRF_NUM_REGS; i++)
        begin
            regs_next[i] = regs_reg[i];
        end
        if (ptr_update)
        begin
            regs_next[ptr_base] = ptr_new[7:0];
            regs_next[ptr_base + 5'h01] = ptr_new[15:8];
        end
        if (data_req.valid && data_req.wen && in_reg_range(acc_addr))
        begin
            regs_next[acc_addr[4:0]] = data_req.wdata;
        end
        if (wr_en)
        begin
            case (port_cfg)
                crf_pkg::PORT_R2_W16,
                crf_pkg::PORT_R16_W16:
                begin
                    regs_next[pair_reg(wr_addr, 1'b0)] = wr_data[7:0];
                    regs_next[pair_reg(wr_addr, 1'b1)] = wr_data[15:8];
                end
                default:
                begin
                    regs_next[wr_addr] = wr_data[7:0];
                end
            endcase
        end
    end

    // Operand and access read data
    always_comb
    begin
        rd_a_next = regs_reg[rd_addr_a];
        rd_b_next = 8'h00;
        rd_w_next = 16'h0000;
        case (port_cfg)
            crf_pkg::PORT_R2_W8,
            crf_pkg::PORT_R2_W16: rd_b_next = regs_reg[rd_addr_b];
            crf_pkg::PORT_R16_W16:
                rd_w_next = {regs_reg[pair_reg(rd_addr_a, 1'b1)],
                             regs_reg[pair_reg(rd_addr_a, 1'b0)]};
            default: rd_b_next = 8'h00;
        endcase
        data_r_next = 8'h00;
        data_hit_next = 1'b0;
        if (data_req.valid)
        begin
            if (in_reg_range(acc_addr))
            begin
                data_r_next = regs_reg[acc_addr[4:0]];
                data_hit_next = 1'b1;
            end
            else if (in_io_window(acc_addr) && sp_hit(io_of_data(acc_addr)))
            begin
                data_r_next = sp_byte(io_of_data(acc_addr), sp_value);
                data_hit_next = 1'b1;
            end
        end
        io_r_next = 8'h00;
        io_hit_next = 1'b0;
        if (io_en && sp_hit(io_addr))
        begin
            io_r_next = sp_byte(io_addr, sp_value);
            io_hit_next = 1'b1;
        end
    end

    // Working registers, single clock domain, no division
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `CRF_NUM_REGS; i++)
            begin
                regs_reg[i] <= `CRF_REG_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < `CRF_NUM_REGS; i++)
            begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // Operand and access outputs, shown one cycle after the request
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_a_reg <= 8'h00;
            rd_b_reg <= 8'h00;
            rd_w_reg <= 16'h0000;
            data_r_reg <= 8'h00;
            data_hit_reg <= 1'b0;
            io_r_reg <= 8'h00;
            io_hit_reg <= 1'b0;
        end
        else
        begin
            rd_a_reg <= rd_a_next;
            rd_b_reg <= rd_b_next;
            rd_w_reg <= rd_w_next;
            data_r_reg <= data_r_next;
            data_hit_reg <= data_hit_next;
            io_r_reg <= io_r_next;
            io_hit_reg <= io_hit_next;
        end
    end

    assign rd_data_a = rd_a_reg;
    assign rd_data_b = rd_b_reg;
    assign rd_data_wide = rd_w_reg;
    assign data_rdata = data_r_reg;
    assign data_hit = data_hit_reg;
    assign io_rdata = io_r_reg;
    assign io_hit = io_hit_reg;
    assign stack_pointer = sp_value;
endmodule // crf_core_regs

// ### crf_core_regs_asserts.sv
/*
 Stack pointer and I/O port assertions for the register file.
 Assumes binding to crf_core_regs.
*/
`timescale 1ns/100ps
module crf_core_regs_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire crf_pkg::crf_sp_op_t sp_op,
    input wire logic [10:0] stack_pointer,
    input wire logic io_en,
    input wire logic io_wen,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_hit,
    input wire crf_pkg::crf_data_req_t data_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic quiet;
    logic [7:0] sp_lo;
    logic [7:0] sp_hi;
    assign quiet = !(io_en && io_wen) && !(data_req.valid && data_req.wen);
    assign sp_lo = stack_pointer[7:0];
    assign sp_hi = {5'h00, stack_pointer[10:8]};
    push_byte_a: assert property (
        quiet && sp_op == crf_pkg::SP_PUSH_BYTE |=> stack_pointer == $past(stack_pointer) - 11'h001)
        else $error("push byte step");
    pop_byte_a: assert property (
        quiet && sp_op == crf_pkg::SP_POP_BYTE |=> stack_pointer == $past(stack_pointer) + 11'h001)
        else $error("pop byte step");
    push_addr_a: assert property (
        quiet && sp_op == crf_pkg::SP_PUSH_ADDR |=> stack_pointer == $past(stack_pointer) - 11'h002)
        else $error("call step");
    pop_addr_a: assert property (
        quiet && sp_op == crf_pkg::SP_POP_ADDR |=> stack_pointer == $past(stack_pointer) + 11'h002)
        else $error("return step");
    io_low_rd_a: assert property (
        io_en && !io_wen && io_addr == 6'h3D |=> io_hit && io_rdata == $past(sp_lo))
        else $error("low byte read");
    io_high_rd_a: assert property (
        io_en && !io_wen && io_addr == 6'h3E |=> io_hit && io_rdata == $past(sp_hi))
        else $error("high byte read");
    io_low_wr_a: assert property (
        io_en && io_wen && io_addr == 6'h3D && sp_op == crf_pkg::SP_HOLD |=> sp_lo == $past(io_wdata))
        else $error("low byte write");
    reset_sp_a: assert property (
        $rose(rst_n) |-> stack_pointer == 11'h4FF)
        else $error("reset value");
    cover property (sp_op == crf_pkg::SP_PUSH_ADDR);
    cover property (sp_op == crf_pkg::SP_POP_BYTE);
    cover property (io_en && io_addr == 6'h3E);
endmodule // crf_core_regs_asserts

bind crf_core_regs crf_core_regs_asserts u_asserts (.clock(clock), .rst_n(rst_n), .sp_op(sp_op),
    .stack_pointer(stack_pointer), .io_en(io_en), .io_wen(io_wen), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .data_req(data_req));

// ### crf_core_model.sv
/*
 Core-side stack request source for the register file.
 Assumes commands from the bench, changed just after clock edges.
*/
`timescale 1ns/100ps
module crf_core_model (
    // Control
    input wire logic sp_ready,
    input wire crf_pkg::crf_sp_op_t cmd,
    // Request
    output crf_pkg::crf_sp_op_t sp_op
);
    // No call or return until software has placed the stack
    assign sp_op = (!sp_ready && cmd >= crf_pkg::SP_PUSH_ADDR) ? crf_pkg::SP_HOLD : cmd;
endmodule // crf_core_model

// ### crf_core_regs_tb.sv
/*
 Self-checking bench for the core register file.
 Assumes the default stack pointer high byte.
*/
`timescale 1ns/100ps
module crf_core_regs_tb;
    typedef struct packed {
        crf_pkg::crf_port_cfg_t cfg;
        logic [4:0] a;
        logic [4:0] b;
        logic wen;
        logic [4:0] waddr;
        logic [15:0] wdata;
        logic ioen;
        logic iowen;
        logic [5:0] ioaddr;
        logic [7:0] iowdata;
        crf_pkg::crf_ptr_req_t ptr;
        crf_pkg::crf_data_req_t dat;
        crf_pkg::crf_sp_op_t cmd;
    } crf_stim_t;
    typedef struct {int kind; logic [15:0] exp;} crf_note_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sp_ready = 1'b0;
    crf_stim_t s = '0;
    crf_stim_t d = '0;
    crf_pkg::crf_sp_op_t sp_op;
    logic [7:0] rd_data_a, rd_data_b, data_rdata, io_rdata, b;
    logic [15:0] rd_data_wide;
    logic data_hit, io_hit;
    logic [10:0] stack_pointer, sp;
    logic [15:0] ptr_eff_addr, eff_seen;
    logic [7:0] rf [32];
    crf_note_t q [$];
    logic [15:0] eq [$];
    crf_note_t n;
    int miscompares = 0, samples_checked = 0, cycles = 0, i, k;
    integer seed = 32'he30c;

    crf_core_regs u_dut (.clock(clock), .rst_n(rst_n), .port_cfg(d.cfg), .rd_addr_a(d.a),
        .rd_addr_b(d.b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
        .rd_data_wide(rd_data_wide), .wr_en(d.wen), .wr_addr(d.waddr), .wr_data(d.wdata),
        .ptr_req(d.ptr), .ptr_eff_addr(ptr_eff_addr), .data_req(d.dat), .data_rdata(data_rdata),
        .data_hit(data_hit), .io_en(d.ioen), .io_wen(d.iowen), .io_addr(d.ioaddr),
        .io_wdata(d.iowdata), .io_rdata(io_rdata), .io_hit(io_hit), .sp_op(sp_op),
        .stack_pointer(stack_pointer));
    crf_core_model u_core (.sp_ready(sp_ready), .cmd(d.cmd), .sp_op(sp_op));

    initial forever #20 clock = ~clock;

    // Effective address is combinational: take it mid-cycle while the request stands
    always @(negedge clock) eff_seen = ptr_eff_addr;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task results;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Apply one request, note its result, release after the next edge
    task tick(input int kind, input logic [15:0] exp);
        d = s;
        s = '0;
        q.push_back('{kind, exp});
        @(posedge clock);
        #1;
    endtask

    task ptr_case(input logic [1:0] sel, input crf_pkg::crf_ptr_mode_t m, input logic [5:0] dp,
        input logic [4:0] tgt, input logic [15:0] nv);
        s.ptr = {1'b1, sel, m, dp};
        s.dat = {1'b1, 16'h0000, 8'h00, 1'b0};
        eq.push_back({11'h000, tgt});
        tick(7, {8'h01, rf[tgt]});
        s.cfg = crf_pkg::PORT_R16_W16;
        s.a = 5'h1A + {sel, 1'b0};
        tick(5, nv);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            results();
        end
    end

    always @(posedge clock)
        if (rst_n && q.size() > 0)
        begin
            n = q.pop_front();
            #2;
            case (n.kind)
                1: check({5'h00, stack_pointer}, n.exp);
                2: check({7'h00, io_hit, io_rdata}, n.exp);
                3: check({7'h00, data_hit, data_rdata}, n.exp);
                4: check({8'h00, rd_data_a}, n.exp);
                5: check(rd_data_wide, n.exp);
                6: check({8'h00, rd_data_b}, n.exp);
                7:
                begin
                    check({7'h00, data_hit, data_rdata}, n.exp);
                    check(eff_seen, eq.pop_front());
                end
                default: ;
            endcase
        end

    initial
    begin
        repeat (4) @(posedge clock);
        #1;
        rst_n = 1'b1;
        sp = 11'h4FF;
        s.cmd = crf_pkg::SP_PUSH_ADDR;
        tick(1, {5'h00, sp});
        for (i = 0; i < 32; i++)
        begin
            b = 8'($random(seed));
            rf[i] = b;
            s.dat = {1'b1, 16'(i), b, 1'b1};
            tick(0, 16'h0000);
        end
        for (i = 0; i < 32; i++)
        begin
            s.a = 5'(i);
            s.dat = {1'b1, 16'(i), 8'h00, 1'b0};
            tick(i[0] ? 4 : 3, {7'h00, ~i[0], rf[i]});
        end
        s.dat = {1'b1, 16'h0040, 8'h00, 1'b0};
        tick(3, 16'h0000);
        s.ioen = 1'b1;
        s.ioaddr = 6'h10;
        tick(2, 16'h0000);
        s.cfg = crf_pkg::PORT_R2_W8;
        s.a = 5'h03;
        s.b = 5'h07;
        tick(6, {8'h00, rf[7]});
        b = 8'($random(seed));
        s.cfg = crf_pkg::PORT_R2_W8;
        s.a = 5'h09;
        s.b = 5'h08;
        s.wen = 1'b1;
        s.waddr = 5'h09;
        s.wdata = {8'h5A, b};
        tick(6, {8'h00, rf[8]});
        rf[9] = b;
        s.cfg = crf_pkg::PORT_R16_W16;
        s.a = 5'h08;
        tick(5, {rf[9], rf[8]});
        for (k = 0; k < 3; k++)
        begin
            s.cfg = crf_pkg::PORT_R2_W16;
            s.wen = 1'b1;
            s.waddr = 5'(26 + 2 * k);
            s.wdata = (k == 0) ? 16'h0005 : (k == 1) ? 16'h0010 : 16'h0002;
            tick(0, 16'h0000);
        end
        ptr_case(2'd0, crf_pkg::PTR_POST_INC, 6'h00, 5'h05, 16'h0006);
        ptr_case(2'd1, crf_pkg::PTR_PRE_DEC, 6'h00, 5'h0F, 16'h000F);
        ptr_case(2'd2, crf_pkg::PTR_DISP, 6'h03, 5'h05, 16'h0002);
        s.ioen = 1'b1;
        s.iowen = 1'b1;
        s.ioaddr = 6'h3E;
        s.iowdata = 8'hFF;
        tick(0, 16'h0000);
        s.ioen = 1'b1;
        s.ioaddr = 6'h3E;
        tick(2, 16'h0107);
        s.ioen = 1'b1;
        s.iowen = 1'b1;
        s.ioaddr = 6'h3D;
        s.iowdata = 8'h40;
        tick(0, 16'h0000);
        s.dat = {1'b1, 16'h005D, 8'h00, 1'b0};
        tick(3, 16'h0140);
        b = 8'($random(seed));
        sp = {3'h2, b};
        s.dat = {1'b1, 16'h005E, 8'h02, 1'b1};
        tick(0, 16'h0000);
        s.dat = {1'b1, 16'h005D, b, 1'b1};
        tick(0, 16'h0000);
        s.ioen = 1'b1;
        s.ioaddr = 6'h3D;
        tick(2, {8'h01, sp[7:0]});
        sp_ready = 1'b1;
        for (i = 0; i < 40; i++)
        begin
            k = $random(seed) & 3;
            s.cmd = crf_pkg::crf_sp_op_t'(3'(k + 1));
            sp = sp + ((k == 0) ? -11'h001 : (k == 1) ? 11'h001 : (k == 2) ? -11'h002 : 11'h002);
            tick(1, {5'h00, sp});
        end
        s.dat = {1'b1, 16'h005D, 8'h00, 1'b0};
        tick(3, {8'h01, sp[7:0]});
        tick(0, 16'h0000);
        rst_n = 1'b0;
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        tick(1, 16'h04FF);
        s.dat = {1'b1, 16'h0005, 8'h00, 1'b0};
        tick(3, 16'h0100);
        tick(0, 16'h0000);
        results();
    end
endmodule // crf_core_regs_tb
